/* src/pin_route.sv */
// routing of one pin according to its selection code
// assumes a synchronised pin level and peripheral drives on the same clock
`timescale 1ns/100ps
`default_nettype none
module pin_route
   import pmap_pkg::*;
(
   // selection
   input wire logic [4:0] code,
   input wire logic port_dir,
   // peripheral side
   input wire periph_out_type periph_out,
   output periph_in_type contrib,
   // pin side
   input wire logic pin_in,
   output pad_drive_type drive
);

   logic [4:0] timer_idx;
   logic [4:0] serial_idx;
   serial_drive_type sd;

   always_comb begin
      timer_idx = code - map_timer7_channel0;
      serial_idx = code - map_serial_a1_receive;
      sd = '0;
      contrib = '0;
      drive = '0;
      drive.oe = port_dir;
      case (code) inside
         map_timer7_clock_in: begin
            contrib.clock_in = pin_in;
         end
         map_dma_ext_trigger: begin
            contrib.dma_trigger = pin_in;
         end
         map_timer7_hiz_control: begin
            contrib.hiz_in = pin_in;
         end
         [map_timer7_channel0:map_timer7_channel6]: begin
            contrib.capture_a[timer_idx[2:0]] = pin_in;
            drive.dout = periph_out.compare_out[timer_idx[2:0]];
         end
         [map_serial_a1_receive:map_serial_b1_clock]: begin
            sd = periph_out.serial[serial_idx[2:0]];
            contrib.serial_in[serial_idx[2:0]] = pin_in;
            if (sd.open_drain) begin
               drive.dout = 1'b0;
               drive.oe = sd.oe & ~sd.dout;
            end else begin
               drive.dout = sd.dout;
               drive.oe = sd.oe;
            end
         end
         map_comparator_result: begin
            drive.dout = periph_out.comp_result;
         end
         map_analog_pin: begin
            drive.oe = 1'b0;
            drive.schmitt_off = 1'b1;
         end
         default: begin
            drive.dout = 1'b0;
         end
      endcase
   end

endmodule : pin_route
`default_nettype wire

/* src/pin_sync.sv */
// two-flop synchroniser for the port pin levels
// assumes pins are asynchronous to the system clock
`timescale 1ns/100ps
`default_nettype none
module pin_sync
   import pmap_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [7:0] async_in,
   output logic [7:0] sync_out
);

   logic [7:0] stage1_ff;
   logic [7:0] stage2_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_ff <= 8'h00;
         stage2_ff <= 8'h00;
      end else begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign sync_out = stage2_ff;

endmodule : pin_sync
`default_nettype wire

/* src/pmap_pkg.sv */
// constants and carrier types for the eight-pin port function mapper
// assumes one system clock and an active-low asynchronous reset
//
// Contract
// - software picks, per pin, which peripheral function uses it, at run time
// - code 1 makes the pin the timer7 external clock input only
// - code 2 makes the pin the external dma trigger input only
// - code 3 makes the pin the timer7 high-impedance control input
// - codes 4..10 join pin to timer7 channels 0..6, capture in, compare out
// - code 11 joins serial_a1 receive or spi slave-out; serial sets direction
// - code 12 joins serial_a1 transmit or spi slave-in; serial sets direction
// - code 13 joins serial_b1 slave enable or serial_a1 clock
// - code 14 joins serial_b1 spi slave-out or i2c clock, open drain in i2c
// - code 15 joins serial_b1 spi slave-in or i2c data, open drain in i2c
// - code 16 joins serial_b1 clock or serial_a1 slave enable
// - code 17 drives the comparator result out, no input function
// - codes 19..30 reserved: no input function, output at ground level
// - selection holds five bits only; writing all ones reads back 31
// - code 31 marks pin analog and turns its schmitt trigger off
// - after reset pins 0..5 carry serial functions, pins 6..7 none
package pmap_pkg;

   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int pin_count = 8;
   localparam int code_width = 5;
   localparam int timer_channels = 7;
   localparam int serial_lines = 6;
   localparam int sync_stages = 2;

   // ****************************************************************
   // selection codes
   // ****************************************************************
   localparam logic [4:0] map_no_function = 5'h00;
   localparam logic [4:0] map_timer7_clock_in = 5'h01;
   localparam logic [4:0] map_dma_ext_trigger = 5'h02;
   localparam logic [4:0] map_timer7_hiz_control = 5'h03;
   localparam logic [4:0] map_timer7_channel0 = 5'h04;
   localparam logic [4:0] map_timer7_channel6 = 5'h0A;
   localparam logic [4:0] map_serial_a1_receive = 5'h0B;
   localparam logic [4:0] map_serial_a1_transmit = 5'h0C;
   localparam logic [4:0] map_serial_a1_clock = 5'h0D;
   localparam logic [4:0] map_serial_b1_i2c_clock = 5'h0E;
   localparam logic [4:0] map_serial_b1_i2c_data = 5'h0F;
   localparam logic [4:0] map_serial_b1_clock = 5'h10;
   localparam logic [4:0] map_comparator_result = 5'h11;
   localparam logic [4:0] map_reserved_first = 5'h13;
   localparam logic [4:0] map_reserved_last = 5'h1E;
   localparam logic [4:0] map_analog_pin = 5'h1F;

   // ****************************************************************
   // values after reset, pin 7 first
   // ****************************************************************
   localparam logic [7:0][4:0] select_reset = {
      map_no_function, map_no_function,
      map_serial_a1_receive, map_serial_a1_transmit,
      map_serial_b1_clock, map_serial_b1_i2c_clock,
      map_serial_b1_i2c_data, map_serial_a1_clock};

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic dout;
      logic oe;
      logic open_drain;
   } serial_drive_type;

   typedef struct packed {
      logic [6:0] compare_out;
      logic comp_result;
      serial_drive_type [5:0] serial;
   } periph_out_type;

   typedef struct packed {
      logic clock_in;
      logic hiz_in;
      logic dma_trigger;
      logic [6:0] capture_a;
      logic [5:0] serial_in;
   } periph_in_type;

   typedef struct packed {
      logic dout;
      logic oe;
      logic schmitt_off;
   } pad_drive_type;

endpackage : pmap_pkg

/* src/port_function_mapper.sv */
// top of the eight-pin port function mapper
// assumes selection writes and port direction come from logic on MCLK
`timescale 1ns/100ps
`default_nettype none
module port_function_mapper
   import pmap_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // selection write and read back
   input wire logic [7:0] SEL_WE,
   input wire logic [7:0] SEL_WDATA,
   output logic [7:0][4:0] SEL_RDATA,
   // normal port direction
   input wire logic [7:0] PORT_DIR,
   // peripheral side
   input wire periph_out_type PERIPH_OUT,
   output periph_in_type PERIPH_IN,
   // pins
   input wire logic [7:0] PIN_IN,
   output logic [7:0] PIN_OUT,
   output logic [7:0] PIN_OE,
   output logic [7:0] PIN_SCHMITT_OFF
);

   // ****************************************************************
   // selection registers
   // ****************************************************************
   logic [7:0][4:0] select_ff;
   logic [7:0][4:0] nxt_select;

   always_comb begin
      nxt_select = select_ff;
      for (int p = 0; p < pin_count; p++) begin
         if (SEL_WE[p]) begin
            nxt_select[p] = SEL_WDATA[4:0];
         end
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         select_ff <= select_reset;
      end else begin
         select_ff <= nxt_select;
      end
   end

   assign SEL_RDATA = select_ff;

   // ****************************************************************
   // pin input synchroniser
   // ****************************************************************
   logic [7:0] pin_sync_lvl;

   pin_sync u_pin_sync (
      .clk(MCLK),
      .rst_n(RST_N),
      .async_in(PIN_IN),
      .sync_out(pin_sync_lvl)
   );

   // ****************************************************************
   // per-pin routing
   // ****************************************************************
   periph_in_type [7:0] contrib;
   pad_drive_type [7:0] drive;

   genvar g;
   generate
      for (g = 0; g < pin_count; g++) begin : g_pin
         pin_route u_route (
            .code(select_ff[g]),
            .port_dir(PORT_DIR[g]),
            .periph_out(PERIPH_OUT),
            .contrib(contrib[g]),
            .pin_in(pin_sync_lvl[g]),
            .drive(drive[g])
         );
      end
   endgenerate

   // ****************************************************************
   // output registers
   // ****************************************************************
   periph_in_type periph_in_ff;
   periph_in_type nxt_periph_in;
   logic [7:0] pin_out_ff;
   logic [7:0] pin_oe_ff;
   logic [7:0] schmitt_off_ff;
   logic [7:0] nxt_pin_out;
   logic [7:0] nxt_pin_oe;
   logic [7:0] nxt_schmitt_off;

   always_comb begin
      nxt_periph_in = '0;
      for (int p = 0; p < pin_count; p++) begin
         nxt_periph_in = nxt_periph_in | contrib[p];
         nxt_pin_out[p] = drive[p].dout;
         nxt_pin_oe[p] = drive[p].oe;
         nxt_schmitt_off[p] = drive[p].schmitt_off;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         periph_in_ff <= '0;
         pin_out_ff <= 8'h00;
         pin_oe_ff <= 8'h00;
         schmitt_off_ff <= 8'h00;
      end else begin
         periph_in_ff <= nxt_periph_in;
         pin_out_ff <= nxt_pin_out;
         pin_oe_ff <= nxt_pin_oe;
         schmitt_off_ff <= nxt_schmitt_off;
      end
   end

   assign PERIPH_IN = periph_in_ff;
   assign PIN_OUT = pin_out_ff;
   assign PIN_OE = pin_oe_ff;
   assign PIN_SCHMITT_OFF = schmitt_off_ff;

endmodule : port_function_mapper
`default_nettype wire

/* testbench/periph_model.sv */
// peripheral side model feeding the mapper
// assumes the bench sets the wanted drive between edges
`timescale 1ns/100ps
`default_nettype none
module periph_model
   import pmap_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // wanted and registered drive
   input wire periph_out_type want,
   output var periph_out_type drive
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drive <= '0;
      end else begin
         drive <= want;
      end
   end
endmodule : periph_model
`default_nettype wire

/* testbench/pfm_chk.sv */
// assertions on the port function mapper top ports
// assumes a bind onto port_function_mapper
`timescale 1ns/100ps
`default_nettype none
module pfm_chk
   import pmap_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // selection
   input wire logic [7:0] SEL_WE,
   input wire logic [7:0] SEL_WDATA,
   input wire logic [7:0][4:0] SEL_RDATA,
   input wire logic [7:0] PORT_DIR,
   // peripherals
   input wire periph_out_type PERIPH_OUT,
   input wire periph_in_type PERIPH_IN,
   // pins
   input wire logic [7:0] PIN_IN,
   input wire logic [7:0] PIN_OUT,
   input wire logic [7:0] PIN_OE,
   input wire logic [7:0] PIN_SCHMITT_OFF
);
   // ***************************************
   // assertions
   // ***************************************
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   sequence s_cap_sel;
      (RST_N && SEL_RDATA[1] == 5'h04 && SEL_RDATA[0] != 5'h04) [*4];
   endsequence
   property p_wr;
      SEL_WE[0] |=> SEL_RDATA[0] == $past(SEL_WDATA[4:0]);
   endproperty
   a_wr: assert property (p_wr) else $error("code not stored");
   property p_hold;
      !SEL_WE[0] |=> $stable(SEL_RDATA[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("code moved");
   property p_cmp;
      SEL_RDATA[0] == 5'h11 |=> PIN_OUT[0] == $past(PERIPH_OUT.comp_result)
         && PIN_OE[0] == $past(PORT_DIR[0]);
   endproperty
   a_cmp: assert property (p_cmp) else $error("bad comparator");
   property p_res;
      SEL_RDATA[6] >= 5'h13 && SEL_RDATA[6] <= 5'h1E |=> !PIN_OUT[6];
   endproperty
   a_res: assert property (p_res) else $error("reserved drives");
   property p_ana;
      SEL_RDATA[7] == 5'h1F |=> PIN_SCHMITT_OFF[7] && !PIN_OE[7];
   endproperty
   a_ana: assert property (p_ana) else $error("analog pin wrong");
   property p_ch;
      SEL_RDATA[1] == 5'h04 |=> PIN_OUT[1] == $past(PERIPH_OUT.compare_out[0]);
   endproperty
   a_ch: assert property (p_ch) else $error("compare out wrong");
   property p_cap;
      s_cap_sel |-> PERIPH_IN.capture_a[0] == $past(PIN_IN[1], 3);
   endproperty
   a_cap: assert property (p_cap) else $error("capture wrong");
   property p_ser;
      SEL_RDATA[5] == 5'h0B && !PERIPH_OUT.serial[0].open_drain |=>
         PIN_OUT[5] == $past(PERIPH_OUT.serial[0].dout)
         && PIN_OE[5] == $past(PERIPH_OUT.serial[0].oe);
   endproperty
   a_ser: assert property (p_ser) else $error("serial drive wrong");
   property p_od;
      SEL_RDATA[2] == 5'h0E && PERIPH_OUT.serial[3].open_drain |=> !PIN_OUT[2]
         && PIN_OE[2] == $past(PERIPH_OUT.serial[3].oe
         & ~PERIPH_OUT.serial[3].dout);
   endproperty
   a_od: assert property (p_od) else $error("open drain wrong");
endmodule : pfm_chk
bind port_function_mapper pfm_chk u_chk (.MCLK(MCLK), .RST_N(RST_N),
   .SEL_WE(SEL_WE), .SEL_WDATA(SEL_WDATA), .SEL_RDATA(SEL_RDATA),
   .PORT_DIR(PORT_DIR), .PERIPH_OUT(PERIPH_OUT), .PERIPH_IN(PERIPH_IN),
   .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
   .PIN_SCHMITT_OFF(PIN_SCHMITT_OFF));
`default_nettype wire

/* testbench/port_function_mapper_tb.sv */
// self-checking bench for the port function mapper
// assumes periph_model drives the peripheral side
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD %0t %h %h", $time, (a), (b)); end end
module port_function_mapper_tb
   import pmap_pkg::*;
;
   logic mclk, rst_n;
   logic [7:0] sel_we, sel_wdata, port_dir, pin_in, pin_out, pin_oe, schm;
   logic [7:0][4:0] sel_rdata;
   periph_out_type want, periph_out;
   periph_in_type periph_in;
   int error_cnt, num_checks;
   periph_model u_model (.clk(mclk), .rst_n(rst_n), .want(want),
      .drive(periph_out));
   port_function_mapper u_dut (.MCLK(mclk), .RST_N(rst_n), .SEL_WE(sel_we),
      .SEL_WDATA(sel_wdata), .SEL_RDATA(sel_rdata), .PORT_DIR(port_dir),
      .PERIPH_OUT(periph_out), .PERIPH_IN(periph_in), .PIN_IN(pin_in),
      .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_SCHMITT_OFF(schm));
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   task automatic wr(input int p, input logic [7:0] d);
      sel_we = 8'h01 << p;
      sel_wdata = d;
      step(1);
      sel_we = 8'h00;
      step(3);
   endtask : wr
   task automatic t_serial;
      want.serial[0] = 3'b110;
      want.serial[1] = 3'b110;
      want.serial[2] = 3'b100;
      want.serial[3] = 3'b011;
      want.serial[4] = 3'b111;
      want.serial[5] = 3'b010;
      pin_in = 8'h3B;
      step(5);
      `CHK({pin_oe[5], pin_out[5]}, 2'b11)
      `CHK(periph_in.serial_in, 6'h37)
      `CHK({pin_oe[2], pin_out[2]}, 2'b10)
      `CHK({pin_oe[4], pin_out[4]}, 2'h3)
      `CHK({pin_oe[0], pin_out[0]}, 2'h1)
      `CHK({pin_oe[1], pin_out[1]}, 2'h0)
      `CHK({pin_oe[3], pin_out[3]}, 2'h2)
   endtask : t_serial
   task automatic t_input;
      pin_in = 8'h08;
      for (int c = 1; c <= 3; c++) begin
         wr(3, 8'(c));
         `CHK(periph_in[15:13], {c == 1, c == 3, c == 2})
         `CHK({periph_in.serial_in, pin_oe[3], pin_out[3]}, 8'h00)
      end
   endtask : t_input
   task automatic t_timer;
      pin_in = 8'h02;
      for (int k = 0; k < 7; k++) begin
         want.compare_out = 7'h01 << k;
         wr(1, 8'(4 + k));
         `CHK(pin_out[1], 1'b1)
         `CHK(periph_in.capture_a, 7'h01 << k)
      end
   endtask : t_timer
   task automatic t_comp;
      want.comp_result = 1'b1;
      wr(0, 8'h11);
      `CHK({pin_oe[0], pin_out[0]}, {port_dir[0], 1'b1})
   endtask : t_comp
   task automatic t_reserved;
      for (int c = 18; c <= 30; c++) begin
         wr(6, 8'(c) | 8'hE0);
         `CHK({pin_oe[6], pin_out[6]}, {port_dir[6], 1'b0})
      end
   endtask : t_reserved
   task automatic t_analog;
      wr(7, 8'hFF);
      `CHK(sel_rdata[7], 5'h1F)
      `CHK({schm[7], pin_oe[7]}, 2'b10)
   endtask : t_analog
   task automatic results;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      error_cnt++;
      results();
   end
   initial begin
      rst_n = 1'b0;
      sel_we = 8'h00;
      sel_wdata = 8'h00;
      port_dir = 8'hD5;
      pin_in = 8'h00;
      want = '0;
      error_cnt = 0;
      num_checks = 0;
      step(5);
      rst_n = 1'b1;
      step(1);
      `CHK(sel_rdata, {5'h0, 5'h0, 5'h0B, 5'h0C, 5'h10, 5'h0E, 5'h0F, 5'h0D})
      t_serial();
      t_input();
      t_timer();
      t_comp();
      t_reserved();
      t_analog();
      results();
   end
endmodule : port_function_mapper_tb
`default_nettype wire
